// ==== include/saacr_pkg.sv ====
package saacr_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_POLARITY_ORDER = 7'h17;
   localparam logic [6:0] ADDR_INTEG_WINDOW = 7'h39;
   localparam logic [6:0] ADDR_INTEG_CONTROL = 7'h42;
   localparam logic [6:0] ADDR_CHANNEL_GAIN = 7'h55;

   localparam logic [15:0] RST_POLARITY_ORDER = 16'h0000;
   localparam logic [15:0] RST_INTEG_WINDOW = 16'h22fc;
   localparam logic [15:0] RST_INTEG_CONTROL = 16'h1c38;
   localparam logic [15:0] RST_CHANNEL_GAIN = 16'h0000;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int POL_LSB = 0;
   localparam int WIDTH_LSB = 11;
   localparam int OFFSET_LSB = 0;
   localparam int INT_GAIN_LSB = 8;
   localparam int BUF_MODE_BIT = 7;
   localparam int IND_EN_BIT = 6;
   localparam int SHARED_GAIN_LSB = 0;
   localparam int CH2_GAIN_LSB = 0;
   localparam int CH3_GAIN_LSB = 2;
   localparam int CH4_GAIN_LSB = 4;

   // ----------------------------------------------------------------
   // codes and serial frame
   // ----------------------------------------------------------------
   localparam logic [1:0] INT_GAIN_UNDEFINED = 2'h3;
   localparam logic [4:0] FRAME_ADDR_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int STEP_WIDTH_NS = 1000;
   localparam int STEP_OFFSET_PS = 31250;
   localparam int CLK_PERIOD_NS = 20;
   localparam int WIDTH_STEP_CYCLES = STEP_WIDTH_NS / CLK_PERIOD_NS;
endpackage : saacr_pkg

// ==== logic/saacr_sync.sv ====
`timescale 1ns/1ps
module saacr_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // meta_q feeds only the second stage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : saacr_sync

// ==== logic/saacr_top.sv ====
`timescale 1ns/1ps
// Overview of operation
// (R1) channel three gain code 0..3 picks 200/100/50/25 kilohm when individual gain on
// (R2) channel two gain uses the same four-step code, only with individual gain on
// (R3) four-bit polarity field holds one polarity bit per pulse of a group of four
// (R4) bit 0 governs pulse one up to bit 3 governing pulse four
// (R5) after pulse four the polarity pattern restarts at bit 0, repeating indefinitely
// (R6) polarity bit 0 gives normal integration, 1 gives reversed integration
// (R7) five-bit window width in one microsecond steps, default 0x4
// (R8) eleven-bit window offset in 31.25 ns steps, default 0x2fc
// (R9) normal mode integrator gain 00/01/10 selects 400/200/100 kilohm
// (R10) in buffer mode every defined integrator gain code gives unity gain
// (R11) buffer bit clear keeps the normal integrator, default clear
// (R12) buffer bit set turns the integrator into a buffer amplifier
// (R13) individual gain bit set enables per-channel gain, else one shared code
// (R14) host writes zeros to reserved polarity bits and 0x07 in the control top field
module saacr_top
   import saacr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic slot_start,
   input wire logic pulse_done,
   output logic pulse_reverse,
   output logic [1:0] pulse_index,
   output logic [1:0] ch1_gain,
   output logic [1:0] ch2_gain,
   output logic [1:0] ch3_gain,
   output logic [1:0] ch4_gain,
   output logic [1:0] integrator_gain,
   output logic integrator_buffer_mode,
   output logic integrator_unity_gain,
   output logic [4:0] window_width,
   output logic [10:0] window_offset,
   output logic [10:0] window_width_cycles
);
   import saacr_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      // serial receive and transmit
      logic sclk_prev;
      logic [4:0] bit_cnt;
      logic [15:0] rx_sh;
      logic [6:0] addr;
      logic is_write;
      logic [15:0] tx_sh;
      logic miso;
      // pulse sequencer
      logic [1:0] pulse_idx;
      // configuration registers
      logic [15:0] pol_reg;
      logic [15:0] win_reg;
      logic [15:0] ctl_reg;
      logic [15:0] gain_reg;
   } saacr_state_type;

   saacr_state_type s_q;
   saacr_state_type s_d;
   logic rst_sync_n;
   logic [2:0] pins_s;
   logic sclk_s;
   logic cs_n_s;
   logic mosi_s;
   logic [15:0] rdata;
   logic [1:0] shared_gain;
   logic ind_en;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   saacr_sync #(.W(1)) u_rst_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d(1'b1),
      .q(rst_sync_n)
   );

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // select is carried active high so the cleared flops read as deselected,
   // otherwise miso_oe would pulse and a frame would open right after reset
   saacr_sync #(.W(3)) u_pin_sync (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .d({spi_sclk, !spi_cs_n, spi_mosi}),
      .q(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_n_s = !pins_s[1];
   assign mosi_s = pins_s[0];

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      if (s_q.addr == ADDR_POLARITY_ORDER) begin
         rdata = s_q.pol_reg;
      end else if (s_q.addr == ADDR_INTEG_WINDOW) begin
         rdata = s_q.win_reg;
      end else if (s_q.addr == ADDR_INTEG_CONTROL) begin
         rdata = s_q.ctl_reg;
      end else if (s_q.addr == ADDR_CHANNEL_GAIN) begin
         rdata = s_q.gain_reg;
      end else begin
         // unmapped addresses read as zero
         rdata = 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // serial frame and pulse sequencer
   // ----------------------------------------------------------------
   // frame: 7 address bits, 1 write flag, 16 data bits, msb first;
   // mosi taken on rising sclk, miso moved on falling sclk.
   // sclk must stay below about a sixth of core_clk for the sampled edges.
   // a frame cut short by cs_n leaves every register untouched.
   always_comb begin
      s_d = s_q;
      s_d.sclk_prev = sclk_s;
      if (cs_n_s) begin
         s_d.bit_cnt = 5'h00;
         // miso parks low while deselected so no stale bit lingers
         s_d.miso = 1'b0;
      end else if (sclk_s && !s_q.sclk_prev) begin
         s_d.rx_sh = {s_q.rx_sh[14:0], mosi_s};
         // the count stops at a full frame, so extra clocks cannot commit twice
         if (s_q.bit_cnt != FRAME_BITS) begin
            s_d.bit_cnt = s_q.bit_cnt + 5'h01;
         end
         if (s_q.bit_cnt == FRAME_ADDR_BITS - 5'h01) begin
            s_d.addr = s_q.rx_sh[6:0];
            s_d.is_write = mosi_s;
         end
         if (s_q.bit_cnt == FRAME_BITS - 5'h01 && s_q.is_write) begin
            // every field is plain storage; reserved bits keep what the host writes
            if (s_q.addr == ADDR_POLARITY_ORDER) begin
               s_d.pol_reg = {s_q.rx_sh[14:0], mosi_s}; // R3
            end else if (s_q.addr == ADDR_INTEG_WINDOW) begin
               s_d.win_reg = {s_q.rx_sh[14:0], mosi_s}; // R7 R8
            end else if (s_q.addr == ADDR_INTEG_CONTROL) begin
               s_d.ctl_reg = {s_q.rx_sh[14:0], mosi_s}; // R11 R12 R13
            end else if (s_q.addr == ADDR_CHANNEL_GAIN) begin
               s_d.gain_reg = {s_q.rx_sh[14:0], mosi_s};
            end
         end
      end else if (!sclk_s && s_q.sclk_prev) begin
         if (s_q.bit_cnt == FRAME_ADDR_BITS && !s_q.is_write) begin
            s_d.miso = rdata[15];
            s_d.tx_sh = {rdata[14:0], 1'b0};
         end else if (s_q.bit_cnt > FRAME_ADDR_BITS) begin
            s_d.miso = s_q.tx_sh[15];
            s_d.tx_sh = {s_q.tx_sh[14:0], 1'b0};
         end
      end

      // the two-bit index wraps after pulse four back to pulse one
      // slot_start wins over pulse_done in the same cycle
      if (slot_start) begin
         s_d.pulse_idx = 2'h0;
      end else if (pulse_done) begin
         s_d.pulse_idx = s_q.pulse_idx + 2'h1; // R5
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_q <= '{
            sclk_prev: 1'b0,
            bit_cnt: 5'h00,
            rx_sh: 16'h0000,
            addr: 7'h00,
            is_write: 1'b0,
            tx_sh: 16'h0000,
            miso: 1'b0,
            pulse_idx: 2'h0,
            pol_reg: RST_POLARITY_ORDER,
            win_reg: RST_INTEG_WINDOW,
            ctl_reg: RST_INTEG_CONTROL,
            gain_reg: RST_CHANNEL_GAIN
         };
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // serial outputs and pulse polarity
   // ----------------------------------------------------------------
   assign spi_miso = s_q.miso;
   assign spi_miso_oe = !cs_n_s;
   assign pulse_index = s_q.pulse_idx;
   assign pulse_reverse = s_q.pol_reg[POL_LSB + s_q.pulse_idx]; // R4 R6

   // ----------------------------------------------------------------
   // channel gain selection
   // ----------------------------------------------------------------
   assign ind_en = s_q.ctl_reg[IND_EN_BIT];
   assign shared_gain = s_q.ctl_reg[SHARED_GAIN_LSB +: 2];
   // channel one always follows the shared field, also with individual gain on
   assign ch1_gain = shared_gain;
   assign ch2_gain = ind_en ? s_q.gain_reg[CH2_GAIN_LSB +: 2] : shared_gain; // R2 R13
   assign ch3_gain = ind_en ? s_q.gain_reg[CH3_GAIN_LSB +: 2] : shared_gain; // R1 R13
   assign ch4_gain = ind_en ? s_q.gain_reg[CH4_GAIN_LSB +: 2] : shared_gain; // R13

   // ----------------------------------------------------------------
   // integrator and window timing
   // ----------------------------------------------------------------
   assign integrator_gain = s_q.ctl_reg[INT_GAIN_LSB +: 2]; // R9
   assign integrator_buffer_mode = s_q.ctl_reg[BUF_MODE_BIT]; // R11 R12
   // code 3 has no defined meaning in either mode, so it never reports unity
   assign integrator_unity_gain = integrator_buffer_mode && (integrator_gain != INT_GAIN_UNDEFINED); // R10
   assign window_width = s_q.win_reg[WIDTH_LSB +: 5]; // R7
   // offset stays in 31.25 ns steps, not a whole number of 20 ns core_clk cycles, so it is not converted
   assign window_offset = s_q.win_reg[OFFSET_LSB +: 11]; // R8
   assign window_width_cycles = 11'(32'(window_width) * WIDTH_STEP_CYCLES); // R7
endmodule : saacr_top

// ==== sim/saacr_host.sv ====
`timescale 1ns/1ps
module saacr_host (
   input wire logic core_clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // five core cycles high and six low per sclk period leave room for the 2-flop sync plus edge detect
   task automatic xfer(input logic [6:0] a, input logic w, input logic [15:0] d, output logic [15:0] r);
      logic [23:0] f;
      f = {a, w, d};
      r = 16'h0000;
      @(posedge core_clk) spi_cs_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge core_clk) spi_mosi <= f[i];
         repeat (5) @(posedge core_clk);
         spi_sclk <= 1'b1;
         r = {r[14:0], spi_miso};
         repeat (5) @(posedge core_clk);
         spi_sclk <= 1'b0;
      end
      repeat (5) @(posedge core_clk);
      spi_cs_n <= 1'b1;
      // released data line must not keep showing the last bit
      spi_mosi <= ~spi_mosi;
      repeat (5) @(posedge core_clk);
   endtask : xfer
endmodule : saacr_host

// ==== sim/saacr_top_asserts.sv ====
`timescale 1ns/1ps
module saacr_top_asserts (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic spi_cs_n,
   input wire logic slot_start,
   input wire logic pulse_done,
   input wire logic pulse_reverse,
   input wire logic [1:0] pulse_index,
   input wire logic [1:0] ch2_gain,
   input wire logic [1:0] ch3_gain,
   input wire logic [1:0] integrator_gain,
   input wire logic integrator_buffer_mode,
   input wire logic integrator_unity_gain,
   input wire logic [4:0] window_width,
   input wire logic [10:0] window_offset,
   input wire logic [10:0] window_width_cycles
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // settings may only move inside a frame
   sequence cs_idle;
      spi_cs_n [*5];
   endsequence
   start_idx_a: assert property (slot_start |=> pulse_index == 2'h0) else $error("index not cleared");
   step_idx_a: assert property (pulse_done && !slot_start |=> pulse_index == $past(pulse_index) + 2'h1)
      else $error("index did not step");
   hold_idx_a: assert property (!slot_start && !pulse_done |=> $stable(pulse_index)) else $error("index moved");
   unity_gain_a: assert property (integrator_unity_gain == (integrator_buffer_mode && integrator_gain != 2'h3))
      else $error("unity flag wrong");
   width_cycles_a: assert property (window_width_cycles == window_width * 11'h032) else $error("width cycles");
   window_hold_a: assert property (cs_idle |-> $stable(window_width) && $stable(window_offset))
      else $error("window moved");
   gain_hold_a: assert property (cs_idle |-> $stable(ch2_gain) && $stable(ch3_gain)) else $error("gain moved");
   reverse_hold_a: assert property (cs_idle ##0 $stable(pulse_index) |-> $stable(pulse_reverse))
      else $error("polarity moved");
   integ_hold_a: assert property (cs_idle |-> $stable(integrator_gain) && $stable(integrator_buffer_mode))
      else $error("integrator moved");
endmodule : saacr_top_asserts
bind saacr_top saacr_top_asserts u_chk (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .spi_cs_n(spi_cs_n),
   .slot_start(slot_start),
   .pulse_done(pulse_done),
   .pulse_reverse(pulse_reverse),
   .pulse_index(pulse_index),
   .ch2_gain(ch2_gain),
   .ch3_gain(ch3_gain),
   .integrator_gain(integrator_gain),
   .integrator_buffer_mode(integrator_buffer_mode),
   .integrator_unity_gain(integrator_unity_gain),
   .window_width(window_width),
   .window_offset(window_offset),
   .window_width_cycles(window_width_cycles)
);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic slot_start = 1'b0;
   logic pulse_done = 1'b0;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, pulse_reverse, integrator_buffer_mode, integrator_unity_gain;
   logic spi_miso_oe;
   logic [1:0] pulse_index, ch1_gain, ch2_gain, ch3_gain, ch4_gain, integrator_gain;
   logic [4:0] window_width;
   logic [10:0] window_offset, window_width_cycles;
   logic [15:0] rd;
   int n_errors = 0;
   int n_checks = 0;
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   saacr_host u_host (
      .core_clk(core_clk),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso)
   );
   saacr_top u_dut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe),
      .slot_start(slot_start),
      .pulse_done(pulse_done),
      .pulse_reverse(pulse_reverse),
      .pulse_index(pulse_index),
      .ch1_gain(ch1_gain),
      .ch2_gain(ch2_gain),
      .ch3_gain(ch3_gain),
      .ch4_gain(ch4_gain),
      .integrator_gain(integrator_gain),
      .integrator_buffer_mode(integrator_buffer_mode),
      .integrator_unity_gain(integrator_unity_gain),
      .window_width(window_width),
      .window_offset(window_offset),
      .window_width_cycles(window_width_cycles)
   );
   // ----------------
   // helpers
   // ----------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      u_host.xfer(a, 1'b1, d, rd);
   endtask : wr
   task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
      u_host.xfer(a, 1'b0, 16'h0000, rd);
      chk(rd, e);
   endtask : rdchk
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   // ----------------
   // sequence
   // ----------------
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      // the output enable must stay low across reset release while deselected
      repeat (3) begin
         @(negedge core_clk);
         chk(16'(spi_miso_oe), 16'h0000);
      end
      repeat (6) @(posedge core_clk);
      chk(16'(window_width), 16'h0004);
      chk(16'(window_offset), 16'h02fc);
      chk(16'(integrator_buffer_mode), 16'h0000);
      rdchk(7'h17, 16'h0000);
      rdchk(7'h39, 16'h22fc);
      wr(7'h39, 16'hffff);
      chk(16'(window_width_cycles), 16'h060e);
      rdchk(7'h39, 16'hffff);
      rdchk(7'h00, 16'h0000);
      wr(7'h42, 16'h1c41);
      for (int g = 0; g < 4; g++) begin
         wr(7'h55, 16'(3 * g + 3) | 16'(g << 4));
         chk(16'(ch3_gain), 16'(g));
         chk(16'(ch2_gain), 16'(3 - g));
         chk(16'(ch1_gain), 16'h0001);
         chk(16'(ch4_gain), 16'(g));
      end
      wr(7'h42, 16'h1c02);
      chk(16'(ch3_gain), 16'h0002);
      chk(16'(ch2_gain), 16'h0002);
      chk(16'(ch4_gain), 16'h0002);
      chk(16'(ch1_gain), 16'h0002);
      for (int k = 0; k < 8; k++) begin
         wr(7'h42, 16'h1c00 | 16'(k << 7));
         chk(16'(integrator_gain), 16'(k >> 1));
         chk(16'(integrator_unity_gain), 16'(k % 2 == 1 && k < 6));
         chk(16'(integrator_buffer_mode), 16'(k % 2));
      end
      wr(7'h17, 16'h0005);
      @(posedge core_clk) slot_start <= 1'b1;
      @(posedge core_clk) slot_start <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         @(negedge core_clk);
         chk(16'(pulse_index), 16'(k % 4));
         chk(16'(pulse_reverse), 16'((5 >> (k % 4)) & 1));
         @(posedge core_clk) pulse_done <= 1'b1;
         @(posedge core_clk) pulse_done <= 1'b0;
      end
      wrap_up();
   end
endmodule : tb_top
